// ==== shared/delay_glide_regs.svh ====
// Register offsets, field positions, reset values and timing counts
`ifndef DELAY_GLIDE_REGS_SVH
`define DELAY_GLIDE_REGS_SVH

`define ADDR_MODE           4'h0
`define ADDR_DELAY_CTRL     4'h1
`define ADDR_COARSE_TARGET  4'h2
`define ADDR_FINE           4'h3
`define ADDR_STATUS         4'h4
`define ADDR_COARSE_ACTIVE  4'h5

`define MODE_SINGLE_BIT     0
`define CTRL_INVERT_BIT     0
`define CTRL_GLIDE_EN_BIT   1
`define CTRL_GLIDE_FAST_BIT 2
`define STAT_BUSY_BIT       0

`define CODE_RESET          8'h00
`define GLIDE_PERIOD_CYC    384
`define GLIDE_SLOW_STEP     8'h01
`define GLIDE_FAST_STEP     8'h04

`endif

// ==== shared/delay_glide_pkg.sv ====
// Types shared by the aperture delay control block
package delay_glide_pkg;
	typedef logic [7:0] code_t;
	typedef logic [3:0] addr_t;
	typedef enum logic [1:0]
	{
		ST_IDLE  = 2'b01,
		ST_GLIDE = 2'b10
	} glide_state_e;
endpackage : delay_glide_pkg

// ==== verilog/glide_tick.sv ====
// Divider giving a one-cycle enable every glide period
`timescale 1ns/1ps
`default_nettype none
module glide_tick #(
	parameter int PERIOD = 384
) (
	// Clock and reset
	input  wire logic i_clock,
	input  wire logic i_reset,
	// Control
	input  wire logic i_restart,
	output logic      o_tick
);
	localparam int W = $clog2(PERIOD);
	logic [W-1:0] count_reg;
	logic [W-1:0] count_next;
	logic         tick_reg;
	logic         tick_next;

	always_comb
	begin
		count_next = count_reg + 1'b1;
		tick_next = 1'b0;
		if (i_restart)
			count_next = '0;
		else if (count_reg == W'(PERIOD - 1))
		begin
			count_next = '0;
			tick_next = 1'b1;
		end
	end

	always_ff @(posedge i_clock)
	begin
		if (i_reset)
		begin
			count_reg <= '0;
			tick_reg <= 1'b0;
		end
		else
		begin
			count_reg <= count_next;
			tick_reg <= tick_next;
		end
	end

	assign o_tick = tick_reg;
endmodule : glide_tick
`default_nettype wire

// ==== verilog/aperture_delay_ramp_ctrl.sv ====
// Aperture delay, edge use and coarse glide control
`timescale 1ns/1ps
`default_nettype none
`include "delay_glide_regs.svh"

// Overview of operation
// (RQ1) Dual-channel mode samples on the rising edge only, once per clock.
// (RQ2) Single-channel mode samples on both edges, twice per clock.
// (RQ3) The invert select flips the device clock, a half-period delay.
// (RQ4) Coarse and fine delays are 8-bit codes with 256 settings each.
// (RQ5) Invert, coarse and fine settings act independently and together.
// (RQ6) All internal clocks follow the same delay settings as sampling.
// (RQ7) Delays may change live; gliding is advised to protect the link.
// (RQ8) With glide enabled the active coarse code steps toward the target.
// (RQ9) Glide speed is one step or four steps per 384 clock cycles.
// (RQ10) Each coarse write while gliding starts a new glide to that value.
// (RQ11) A periodic SYSREF runs at the multiframe or multiblock rate.
// (RQ12) SYSREF may come as a single pulse or as a periodic clock.
// (RQ13) SYSREF is captured on a fixed clock edge with setup and hold met.
// (RQ14) Without glide a coarse write applies at once; glides never overshoot.
// (RQ15) The glide moves up or down and clips its last step to the gap.
module aperture_delay_ramp_ctrl
#(
	parameter int GLIDE_PERIOD = `GLIDE_PERIOD_CYC
) (
	// Clock and reset
	input  wire logic                  i_clock,
	input  wire logic                  i_reset,
	// Register port
	input  wire delay_glide_pkg::addr_t i_addr,
	input  wire logic [7:0]            i_wdata,
	input  wire logic                  i_write,
	input  wire logic                  i_read,
	output logic [7:0]                 o_rdata,
	// SYSREF from pin
	input  wire logic                  i_sysref,
	// Delay controls to clock path
	output logic                       o_clock_invert_sel,
	output delay_glide_pkg::code_t     o_delay_coarse_code,
	output delay_glide_pkg::code_t     o_delay_fine_code,
	// Sampling edge use
	output logic                       o_sample_rise_en,
	output logic                       o_sample_fall_en,
	// Status
	output logic                       o_glide_busy,
	output logic                       o_sysref_capture
);
	import delay_glide_pkg::*;

	logic         single_mode_reg;
	logic         single_mode_next;
	logic         invert_reg;
	logic         invert_next;
	logic         glide_en_reg;
	logic         glide_en_next;
	logic         glide_fast_reg;
	logic         glide_fast_next;
	code_t        target_reg;
	code_t        target_next;
	code_t        fine_reg;
	code_t        fine_next;
	code_t        active_reg;
	code_t        active_next;
	glide_state_e state_reg;
	glide_state_e state_next;
	logic [7:0]   rdata_reg;
	logic [7:0]   rdata_next;
	logic         rise_reg;
	logic         rise_next;
	logic         fall_reg;
	logic         fall_next;
	logic         sysref_meta_reg;
	logic         sysref_sync_reg;
	logic         sysref_cap_reg;
	logic         tick;
	logic         coarse_write;

	// One step toward target, clipped to the remaining gap
	function automatic code_t step_toward(input code_t cur, input code_t tgt,
		input code_t step);
		code_t gap;
		gap = (tgt > cur) ? code_t'(tgt - cur) : code_t'(cur - tgt);
		if (gap < step)
			step_toward = tgt;
		else if (tgt > cur)
			step_toward = code_t'(cur + step);
		else
			step_toward = code_t'(cur - step);
	endfunction : step_toward

	assign coarse_write = i_write && (i_addr == `ADDR_COARSE_TARGET);

	// Period restarts on each new target so every step spans a full period
	glide_tick #(
		.PERIOD (GLIDE_PERIOD)
	) u_tick (
		.i_clock   (i_clock),
		.i_reset   (i_reset),
		.i_restart (coarse_write),
		.o_tick    (tick)
	);

	// Register writes and reads
	always_comb
	begin
		single_mode_next = single_mode_reg;
		invert_next = invert_reg;
		glide_en_next = glide_en_reg;
		glide_fast_next = glide_fast_reg;
		target_next = target_reg;
		fine_next = fine_reg;
		// Read data stands one cycle, zero otherwise
		rdata_next = 8'h00;
		// (RQ7) live delay writes
		if (i_write)
		begin
			unique case (i_addr)
				`ADDR_MODE:
					single_mode_next = i_wdata[`MODE_SINGLE_BIT];
				`ADDR_DELAY_CTRL:
				begin
					// (RQ5) independent fields
					invert_next = i_wdata[`CTRL_INVERT_BIT];
					glide_en_next = i_wdata[`CTRL_GLIDE_EN_BIT];
					glide_fast_next = i_wdata[`CTRL_GLIDE_FAST_BIT];
				end
				`ADDR_COARSE_TARGET:
					target_next = i_wdata;
				`ADDR_FINE:
					fine_next = i_wdata;
				default:
					;
			endcase
		end
		if (i_read)
		begin
			unique case (i_addr)
				`ADDR_MODE:
					rdata_next = {7'h00, single_mode_reg};
				`ADDR_DELAY_CTRL:
					rdata_next = {5'h00, glide_fast_reg, glide_en_reg,
						invert_reg};
				`ADDR_COARSE_TARGET:
					rdata_next = target_reg;
				`ADDR_FINE:
					rdata_next = fine_reg;
				`ADDR_STATUS:
					rdata_next = {7'h00, state_reg == ST_GLIDE};
				`ADDR_COARSE_ACTIVE:
					rdata_next = active_reg;
				default:
					rdata_next = 8'h00;
			endcase
		end
	end

	// Glide engine
	always_comb
	begin
		active_next = active_reg;
		state_next = state_reg;
		unique case (state_reg)
			ST_IDLE:
			begin
				if (coarse_write)
				begin
					// (RQ14) direct apply when off
					if (!glide_en_reg)
						active_next = i_wdata;
					// (RQ10) new glide per write
					else if (i_wdata != active_reg)
						state_next = ST_GLIDE;
				end
			end
			ST_GLIDE:
			begin
				// Coarse write with glide off mid-glide: jump and stop
				if (coarse_write && !glide_en_reg)
				begin
					active_next = i_wdata;
					state_next = ST_IDLE;
				end
				// A retarget skips this tick; the period restarts
				else if (tick && !coarse_write)
				begin
					// (RQ8) (RQ9) (RQ15) step per period
					active_next = step_toward(active_reg, target_reg,
						glide_fast_reg ? `GLIDE_FAST_STEP : `GLIDE_SLOW_STEP);
					// (RQ14) stop exactly at target
					if (active_next == target_reg)
						state_next = ST_IDLE;
				end
			end
			default:
				state_next = ST_IDLE;
		endcase
	end

	// Edge use per channel mode
	// Registered, so a mode write shows two cycles on
	always_comb
	begin
		// (RQ1) rising edge always
		rise_next = 1'b1;
		// (RQ2) falling edge too in single mode
		fall_next = single_mode_reg;
	end

	always_ff @(posedge i_clock)
	begin
		if (i_reset)
		begin
			single_mode_reg <= 1'b0;
			invert_reg <= 1'b0;
			glide_en_reg <= 1'b0;
			glide_fast_reg <= 1'b0;
			target_reg <= `CODE_RESET;
			fine_reg <= `CODE_RESET;
			active_reg <= `CODE_RESET;
			state_reg <= ST_IDLE;
			rdata_reg <= 8'h00;
			rise_reg <= 1'b0;
			fall_reg <= 1'b0;
		end
		else
		begin
			single_mode_reg <= single_mode_next;
			invert_reg <= invert_next;
			glide_en_reg <= glide_en_next;
			glide_fast_reg <= glide_fast_next;
			target_reg <= target_next;
			fine_reg <= fine_next;
			active_reg <= active_next;
			state_reg <= state_next;
			rdata_reg <= rdata_next;
			rise_reg <= rise_next;
			fall_reg <= fall_next;
		end
	end

	// (RQ13) SYSREF synchronised, captured on rising edge
	always_ff @(posedge i_clock)
	begin
		if (i_reset)
		begin
			sysref_meta_reg <= 1'b0;
			sysref_sync_reg <= 1'b0;
			sysref_cap_reg <= 1'b0;
		end
		else
		begin
			sysref_meta_reg <= i_sysref;
			sysref_sync_reg <= sysref_meta_reg;
			// (RQ12) pulse or periodic both flagged per rising edge
			sysref_cap_reg <= sysref_sync_reg;
		end
	end

	// (RQ3) (RQ4) (RQ6) one delay set drives every clock
	assign o_clock_invert_sel = invert_reg;
	assign o_delay_coarse_code = active_reg;
	assign o_delay_fine_code = fine_reg;
	assign o_sample_rise_en = rise_reg;
	assign o_sample_fall_en = fall_reg;
	// One-hot code: the glide bit is the busy flop
	assign o_glide_busy = state_reg[1];
	assign o_sysref_capture = sysref_cap_reg;
	assign o_rdata = rdata_reg;
endmodule : aperture_delay_ramp_ctrl
`default_nettype wire

// ==== dv/sysref_source.sv ====
// Behavioural SYSREF source: single pulse or periodic
`timescale 1ns/1ps
`default_nettype none
module sysref_source #(
	parameter int PERIOD = 16
) (
	input  wire logic i_clock,
	input  wire logic i_periodic,
	input  wire logic i_pulse,
	output logic      o_sysref = 1'b0
);
	int count = 0;
	always @(posedge i_clock)
	begin
		count <= (count + 1) % PERIOD;
		o_sysref <= i_pulse || (i_periodic && count < PERIOD / 2);
	end
endmodule : sysref_source
`default_nettype wire

// ==== dv/aperture_delay_ramp_ctrl_properties.sv ====
// Port-level assertions of the aperture delay control block
`timescale 1ns/1ps
`default_nettype none
`include "delay_glide_regs.svh"
module aperture_delay_ramp_ctrl_properties
	import delay_glide_pkg::*;
#(
	parameter int GLIDE_PERIOD = `GLIDE_PERIOD_CYC
) (
	input wire logic  i_clock,
	input wire logic  i_reset,
	input wire addr_t i_addr,
	input wire code_t i_wdata,
	input wire logic  i_write,
	input wire logic  i_read,
	input wire code_t o_rdata,
	input wire logic  i_sysref,
	input wire logic  o_clock_invert_sel,
	input wire code_t o_delay_coarse_code,
	input wire code_t o_delay_fine_code,
	input wire logic  o_sample_rise_en,
	input wire logic  o_sample_fall_en,
	input wire logic  o_glide_busy,
	input wire logic  o_sysref_capture
);
	// Cycles since the last coarse write, saturating
	logic       en_reg, en_next;
	logic [1:0] live_reg, live_next;
	int         since_reg, since_next;
	always_comb
	begin
		en_next = en_reg;
		// Cycles out of reset, saturating at three
		live_next = (live_reg == 2'h3) ? live_reg : live_reg + 2'h1;
		since_next = (since_reg < 4096) ? since_reg + 1 : since_reg;
		if (i_write && i_addr == `ADDR_DELAY_CTRL)
			en_next = i_wdata[`CTRL_GLIDE_EN_BIT];
		if (i_write && i_addr == `ADDR_COARSE_TARGET)
			since_next = 1;
	end
	always_ff @(posedge i_clock)
	begin
		en_reg <= i_reset ? 1'b0 : en_next;
		since_reg <= i_reset ? 0 : since_next;
		live_reg <= i_reset ? 2'h0 : live_next;
	end
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (i_reset);
	sequence coarse_write;
		i_write && i_addr == `ADDR_COARSE_TARGET;
	endsequence
	// A step lands one cycle after the period ends, seen one sample later
	sequence step_due;
		$past(o_glide_busy) && since_reg > 2 && since_reg % GLIDE_PERIOD == 2;
	endsequence
	rise_edge_a: assert property (!$past(i_reset) |-> o_sample_rise_en)
		else $error("rising edge sampling off");
	single_mode_a: assert property (
		i_write && i_addr == `ADDR_MODE
		|-> ##2 o_sample_fall_en == $past(i_wdata[`MODE_SINGLE_BIT], 2))
		else $error("falling edge use differs from mode");
	invert_set_a: assert property (
		i_write && i_addr == `ADDR_DELAY_CTRL
		|=> o_clock_invert_sel == $past(i_wdata[`CTRL_INVERT_BIT]))
		else $error("inversion differs from written value");
	coarse_direct_a: assert property (coarse_write ##0 !en_reg
		|=> o_delay_coarse_code == $past(i_wdata) && !o_glide_busy)
		else $error("coarse write without glide not applied");
	glide_start_a: assert property (coarse_write ##0 en_reg
		&& i_wdata != o_delay_coarse_code |=> o_glide_busy)
		else $error("glide did not start");
	step_time_a: assert property (
		step_due |-> $changed(o_delay_coarse_code))
		else $error("no glide step at period end");
	step_hold_a: assert property ($past(o_glide_busy)
		&& since_reg > 1 && since_reg % GLIDE_PERIOD != 2
		|-> $stable(o_delay_coarse_code))
		else $error("coarse code moved between steps");
	sysref_lat_a: assert property (
		live_reg == 2'h3 |-> o_sysref_capture == $past(i_sysref, 3))
		else $error("sysref capture latency wrong");
endmodule : aperture_delay_ramp_ctrl_properties
`default_nettype wire

// ==== dv/test_aperture_delay_ramp_ctrl.sv ====
// Self-checking bench for the aperture delay control block
`timescale 1ns/1ps
`default_nettype none
`include "delay_glide_regs.svh"
module test_aperture_delay_ramp_ctrl;
	import delay_glide_pkg::*;
	localparam int P = 8;
	logic  i_clock = 1'b0, i_reset = 1'b1, i_write = 1'b0, i_read = 1'b0;
	logic  periodic = 1'b0, pulse = 1'b0, i_sysref, o_clock_invert_sel;
	logic  o_sample_rise_en, o_sample_fall_en, o_glide_busy, o_sysref_capture;
	addr_t i_addr = 4'h0;
	code_t i_wdata = 8'h00, o_rdata, o_delay_coarse_code, o_delay_fine_code;
	int    n_mismatch = 0, n_checks = 0, cycles = 0, lfsr = 47, cur, f;
	always #5 i_clock = ~i_clock;
	// SYSREF history: bit 2 is the level three edges back
	logic [2:0] sr_hist = 3'h0;
	always @(posedge i_clock)
		sr_hist <= {sr_hist[1:0], i_sysref};
	aperture_delay_ramp_ctrl #(.GLIDE_PERIOD(P)) u_dut (.*);
	sysref_source u_src (.i_clock(i_clock), .i_periodic(periodic),
		.i_pulse(pulse), .o_sysref(i_sysref));
	function automatic int rnd();
		lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
		return lfsr;
	endfunction : rnd
	task automatic check(input code_t seen, input code_t exp);
		n_checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic wr(input addr_t a, input code_t d);
		i_write <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clock);
		i_write <= 1'b0;
		@(posedge i_clock);
	endtask : wr
	task automatic rd(input addr_t a, input code_t exp);
		i_read <= 1'b1;
		i_addr <= a;
		@(posedge i_clock);
		i_read <= 1'b0;
		@(posedge i_clock);
		check(o_rdata, exp);
	endtask : rd
	// Model: count clipped steps, then time the glide
	task automatic glide(input int t, input logic fast);
		int s, c, n, st;
		s = 0;
		c = cur;
		st = fast ? 4 : 1;
		while (c != t)
		begin
			c = (c < t) ? ((t - c > st) ? c + st : t) : ((c - t > st) ? c - st : t);
			s++;
		end
		wr(`ADDR_DELAY_CTRL, fast ? 8'h06 : 8'h02);
		wr(`ADDR_COARSE_TARGET, 8'(t));
		n = 0;
		while (o_glide_busy === 1'b1 && n < 999)
		begin
			@(posedge i_clock);
			n++;
		end
		// Registered tick: first step lands one cycle past the period
		check(8'(n), 8'(s * P + 1));
		check(o_delay_coarse_code, 8'(t));
		cur = t;
	endtask : glide
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : tally_and_finish
	always @(posedge i_clock)
	begin
		cycles <= cycles + 1;
		if (cycles == 5000)
		begin
			n_mismatch++;
			tally_and_finish();
		end
	end
	initial
	begin
		repeat (2) @(posedge i_clock);
		i_reset <= 1'b0;
		repeat (2) @(posedge i_clock);
		check(o_delay_coarse_code, `CODE_RESET);
		for (int m = 0; m < 2; m++)
		begin
			wr(`ADDR_MODE, 8'(m));
			// Edge enables trail the mode bit by one cycle
			rd(`ADDR_MODE, 8'(m));
			check(o_sample_fall_en, 8'(m));
			check(o_sample_rise_en, 8'h01);
		end
		repeat (4)
		begin
			cur = rnd();
			f = rnd();
			wr(`ADDR_DELAY_CTRL, {7'h00, cur[0]});
			wr(`ADDR_FINE, 8'(f));
			wr(`ADDR_COARSE_TARGET, 8'(cur));
			check(o_clock_invert_sel, 8'(cur[0]));
			check(o_delay_fine_code, 8'(f));
			check(o_delay_coarse_code, 8'(cur));
			rd(`ADDR_FINE, 8'(f));
		end
		rd(4'hf, 8'h00);
		wr(`ADDR_COARSE_TARGET, 8'h20);
		cur = 32;
		glide(35, 1'b0);
		glide(25, 1'b1);
		glide(26, 1'b1);
		// Retarget downward after one fast upward step
		wr(`ADDR_COARSE_TARGET, 8'h30);
		rd(`ADDR_STATUS, 8'h01);
		repeat (P - 2) @(posedge i_clock);
		cur = 30;
		glide(20, 1'b0);
		wr(`ADDR_COARSE_TARGET, 8'h40);
		wr(`ADDR_DELAY_CTRL, 8'h00);
		wr(`ADDR_COARSE_TARGET, 8'h05);
		check(o_glide_busy, 8'h00);
		rd(`ADDR_COARSE_ACTIVE, 8'h05);
		rd(`ADDR_COARSE_TARGET, 8'h05);
		rd(`ADDR_DELAY_CTRL, 8'h00);
		periodic <= 1'b1;
		repeat (40)
		begin
			@(posedge i_clock);
			check(o_sysref_capture, sr_hist[2]);
		end
		periodic <= 1'b0;
		pulse <= 1'b1;
		repeat (8)
		begin
			@(posedge i_clock);
			pulse <= 1'b0;
			check(o_sysref_capture, sr_hist[2]);
		end
		tally_and_finish();
	end
endmodule : test_aperture_delay_ramp_ctrl
bind aperture_delay_ramp_ctrl aperture_delay_ramp_ctrl_properties
	#(.GLIDE_PERIOD(GLIDE_PERIOD)) u_props (.*);
`default_nettype wire
